/* File: nsx_regs.svh */
`ifndef NSX_REGS_SVH
`define NSX_REGS_SVH
// opcodes
`define NSX_OP_RR 8'h00
`define NSX_OP_RL 8'h01
`define NSX_OP_RRC 8'h02
`define NSX_OP_RLC 8'h03
`define NSX_OP_SBC 8'h0A
`define NSX_OP_STC 8'h2B
`define NSX_OP_RET 8'h2E
`define NSX_OP_INTERRUPT_RETURN_OP 8'h2F
`define NSX_OP_SUBI 8'h41
`define NSX_OP_SNDN 8'h45
`define NSX_OP_SNDONE 8'h48
`define NSX_OP_SNDLOOP 8'h49
`define NSX_OP_SNDOFF 8'h4A
`define NSX_OP_SNDA 8'h4B
// register byte offsets
`define NSX_REG_CTRL 8'h00
`define NSX_REG_STATE 8'h04
`define NSX_REG_SOUND 8'h08
`define NSX_REG_LASTOP 8'h0C
// fields
`define NSX_CTRL_RUN_BIT 0
`define NSX_ST_CF_BIT 4
`define NSX_ST_SAVED_BIT 5
`define NSX_SND_REP_BIT 4
`define NSX_SND_ACT_BIT 5
// reset values
`define NSX_RST_NIB 4'h0
`define NSX_RST_BYTE 8'h00
`define NSX_RST_RUN 1'h0
// bus answers
`define NSX_RESP_OKAY 2'h0
`define NSX_RESP_SLVERR 2'h2
`endif

/* File: nsx_pkg.sv */
`default_nettype none
package nsx_pkg;
	typedef enum {NSX_FETCH, NSX_OPERAND} nsx_state_t;
	typedef enum {NSX_ALU_NONE, NSX_ALU_RL, NSX_ALU_RLC, NSX_ALU_RR, NSX_ALU_RRC,
		NSX_ALU_SBC, NSX_ALU_SUB, NSX_ALU_STC} nsx_aluop_t;
endpackage : nsx_pkg
`default_nettype wire

/* File: nsx_alu.sv */
`timescale 1ns/1ps
`default_nettype none
module nsx_alu (
	input var nsx_pkg::nsx_aluop_t op,
	input wire logic [3:0] acc,
	input wire logic cf,
	input wire logic [3:0] operand,
	output logic [3:0] acc_nxt,
	output logic cf_nxt
);
	// acc + ~b + cin; the carry out is the not-borrow
	function automatic logic [4:0] nsx_sub(input logic [3:0] a, input logic [3:0] b,
		input logic cin);
		nsx_sub = {1'b0, a} + {1'b0, ~b} + {4'h0, cin};
	endfunction : nsx_sub

	wire [4:0] sbc_res = nsx_sub(acc, operand, cf);
	wire [4:0] sub_res = nsx_sub(acc, operand, 1'b1);

	always_comb
	begin
		acc_nxt = acc;
		cf_nxt = cf;
		case (op)
			nsx_pkg::NSX_ALU_RL:
			begin
				acc_nxt = {acc[2:0], acc[3]};
				cf_nxt = acc[3];
			end
			nsx_pkg::NSX_ALU_RLC:
			begin
				acc_nxt = {acc[2:0], cf};
				cf_nxt = acc[3];
			end
			nsx_pkg::NSX_ALU_RR:
			begin
				acc_nxt = {acc[0], acc[3:1]};
				cf_nxt = acc[0];
			end
			nsx_pkg::NSX_ALU_RRC:
			begin
				acc_nxt = {cf, acc[3:1]};
				cf_nxt = acc[0];
			end
			nsx_pkg::NSX_ALU_SBC:
			begin
				acc_nxt = sbc_res[3:0];
				cf_nxt = sbc_res[4];
			end
			nsx_pkg::NSX_ALU_SUB:
			begin
				acc_nxt = sub_res[3:0];
				cf_nxt = sub_res[4];
			end
			nsx_pkg::NSX_ALU_STC: cf_nxt = 1'b1;
			default: cf_nxt = cf;
		endcase
	end
endmodule : nsx_alu
`default_nettype wire

/* File: nsx_axil.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nsx_regs.svh"
module nsx_axil #(
	parameter int ADDR_W = 8
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wr_en,
	output logic [ADDR_W-1:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_hit,
	input wire logic [31:0] rd_data,
	input wire logic rd_hit
);
	logic aw_held_ff;
	logic w_held_ff;
	logic [ADDR_W-1:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;

	assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
	assign s_axi_wready = !w_held_ff && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	// both halves held: commit once, then answer
	assign wr_en = aw_held_ff && w_held_ff && !s_axi_bvalid;
	assign wr_addr = awaddr_ff;
	assign wr_data = wdata_ff;
	assign wr_strb = wstrb_ff;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff <= '0;
			wstrb_ff <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `NSX_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (wr_en)
			begin
				aw_held_ff <= 1'b0;
				w_held_ff <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `NSX_RESP_OKAY : `NSX_RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `NSX_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_data;
			s_axi_rresp <= rd_hit ? `NSX_RESP_OKAY : `NSX_RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule : nsx_axil
`default_nettype wire

/* File: nsx_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nsx_regs.svh"
module nsx_core #(
	parameter int ADDR_W = 8,
	parameter int PC_W = 12
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic instr_valid,
	input wire logic [7:0] instr_byte,
	output logic instr_ready,
	input wire logic [3:0] pair_addressed_memory,
	input wire logic [PC_W-1:0] stack_pc,
	input wire logic irq_enter,
	input wire logic snd_done,
	output logic pc_load_ff,
	output logic [PC_W-1:0] program_counter_ff,
	output logic retire_ff,
	output logic [3:0] accumulator_nibble_ff,
	output logic carry_flag_ff,
	output logic [3:0] snd_channel_ff,
	output logic snd_repeat_ff,
	output logic snd_active_ff,
	output logic snd_start_ff,
	output logic snd_stop_ff
);
	generate
		if (ADDR_W < 4 || PC_W < 1)
			$error("nsx_core: ADDR_W must be at least 4 and PC_W at least 1");
	endgenerate

	function automatic logic nsx_two_byte(input logic [7:0] op);
		nsx_two_byte = (op == `NSX_OP_SUBI) || (op == `NSX_OP_SNDN);
	endfunction : nsx_two_byte

	function automatic nsx_pkg::nsx_aluop_t nsx_alu_dec(input logic [7:0] op);
		if (op == `NSX_OP_RL)
			nsx_alu_dec = nsx_pkg::NSX_ALU_RL;
		else if (op == `NSX_OP_RLC)
			nsx_alu_dec = nsx_pkg::NSX_ALU_RLC;
		else if (op == `NSX_OP_RR)
			nsx_alu_dec = nsx_pkg::NSX_ALU_RR;
		else if (op == `NSX_OP_RRC)
			nsx_alu_dec = nsx_pkg::NSX_ALU_RRC;
		else if (op == `NSX_OP_SBC)
			nsx_alu_dec = nsx_pkg::NSX_ALU_SBC;
		else if (op == `NSX_OP_SUBI)
			nsx_alu_dec = nsx_pkg::NSX_ALU_SUB;
		else if (op == `NSX_OP_STC)
			nsx_alu_dec = nsx_pkg::NSX_ALU_STC;
		else
			nsx_alu_dec = nsx_pkg::NSX_ALU_NONE;
	endfunction : nsx_alu_dec

	nsx_pkg::nsx_state_t state_ff;
	nsx_pkg::nsx_state_t nxt_state;
	logic run_en_ff;
	logic saved_cf_ff;
	logic [7:0] op_hold_ff;
	logic [7:0] last_op_ff;
	logic wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [31:0] rd_data;
	logic [3:0] alu_acc;
	logic alu_cf;

	// fetch handshake; clearing run stalls the fetch side
	assign instr_ready = run_en_ff;
	wire take = instr_valid && instr_ready;
	wire in_operand = (state_ff == nsx_pkg::NSX_OPERAND);
	wire [7:0] cur_op = in_operand ? op_hold_ff : instr_byte;
	wire exec = take && (in_operand || !nsx_two_byte(instr_byte));
	wire [3:0] imm = instr_byte[3:0];
	// enum is two-state, so it cannot be a net
	nsx_pkg::nsx_aluop_t alu_op;
	assign alu_op = nsx_alu_dec(cur_op);
	wire alu_wr = exec && (alu_op != nsx_pkg::NSX_ALU_NONE);
	// sbc reads memory, the immediate form reads the operand byte
	wire [3:0] alu_operand = (alu_op == nsx_pkg::NSX_ALU_SBC) ? pair_addressed_memory : imm;
	wire is_ret = exec && (cur_op == `NSX_OP_RET);
	wire is_interrupt_return_op = exec && (cur_op == `NSX_OP_INTERRUPT_RETURN_OP);
	wire is_sndn = exec && (cur_op == `NSX_OP_SNDN);
	wire is_snda = exec && (cur_op == `NSX_OP_SNDA);
	wire is_loop = exec && (cur_op == `NSX_OP_SNDLOOP);
	wire is_one = exec && (cur_op == `NSX_OP_SNDONE);
	wire is_off = exec && (cur_op == `NSX_OP_SNDOFF);
	wire snda_hit = is_snda && (accumulator_nibble_ff == snd_channel_ff);
	wire snd_go = is_sndn || snda_hit;

	// register decode
	wire wr_ctrl = wr_en && (wr_addr == `NSX_REG_CTRL);
	wire wr_state = wr_en && (wr_addr == `NSX_REG_STATE);
	wire wr_sound = wr_en && (wr_addr == `NSX_REG_SOUND);
	wire wr_hit = (wr_addr == `NSX_REG_CTRL) || (wr_addr == `NSX_REG_STATE) ||
		(wr_addr == `NSX_REG_SOUND) || (wr_addr == `NSX_REG_LASTOP);
	wire rd_ctrl = (s_axi_araddr == `NSX_REG_CTRL);
	wire rd_state = (s_axi_araddr == `NSX_REG_STATE);
	wire rd_sound = (s_axi_araddr == `NSX_REG_SOUND);
	wire rd_lastop = (s_axi_araddr == `NSX_REG_LASTOP);
	wire rd_hit = rd_ctrl || rd_state || rd_sound || rd_lastop;
	wire [31:0] ctrl_word = {31'h0, run_en_ff};
	wire [31:0] state_word = {26'h0, saved_cf_ff, carry_flag_ff, accumulator_nibble_ff};
	wire [31:0] sound_word = {26'h0, snd_active_ff, snd_repeat_ff, snd_channel_ff};
	wire [31:0] lastop_word = {24'h0, last_op_ff};

	always_comb
	begin
		if (rd_ctrl)
			rd_data = ctrl_word;
		else if (rd_state)
			rd_data = state_word;
		else if (rd_sound)
			rd_data = sound_word;
		else if (rd_lastop)
			rd_data = lastop_word;
		else
			rd_data = 32'h0;
	end

	nsx_axil #(
		.ADDR_W(ADDR_W)
	) u_axil (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_hit(wr_hit),
		.rd_data(rd_data),
		.rd_hit(rd_hit)
	);

	nsx_alu u_alu (
		.op(alu_op),
		.acc(accumulator_nibble_ff),
		.cf(carry_flag_ff),
		.operand(alu_operand),
		.acc_nxt(alu_acc),
		.cf_nxt(alu_cf)
	);

	// all fields live in byte lane 0
	wire lane0 = wr_strb[0];
	logic [3:0] nxt_acc;
	logic nxt_cf;
	logic nxt_active;

	always_comb
	begin
		nxt_state = state_ff;
		if (take && !in_operand && nsx_two_byte(instr_byte))
			nxt_state = nsx_pkg::NSX_OPERAND;
		else if (take)
			nxt_state = nsx_pkg::NSX_FETCH;
	end

	// execution wins over a software write landing in the same cycle
	always_comb
	begin
		nxt_acc = accumulator_nibble_ff;
		nxt_cf = carry_flag_ff;
		if (wr_state && lane0)
		begin
			nxt_acc = wr_data[3:0];
			nxt_cf = wr_data[`NSX_ST_CF_BIT];
		end
		if (alu_wr)
		begin
			nxt_acc = alu_acc;
			nxt_cf = alu_cf;
		end
		else if (is_interrupt_return_op)
			nxt_cf = saved_cf_ff;
	end

	// a start in the same cycle as a finish keeps the sound alive
	always_comb
	begin
		nxt_active = snd_active_ff;
		if (snd_done && !snd_repeat_ff)
			nxt_active = 1'b0;
		if (is_off)
			nxt_active = 1'b0;
		if (snd_go)
			nxt_active = 1'b1;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff <= nsx_pkg::NSX_FETCH;
			op_hold_ff <= `NSX_RST_BYTE;
			last_op_ff <= `NSX_RST_BYTE;
			retire_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			retire_ff <= exec;
			if (take && !in_operand)
				op_hold_ff <= instr_byte;
			if (exec)
				last_op_ff <= cur_op;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			run_en_ff <= `NSX_RST_RUN;
			accumulator_nibble_ff <= `NSX_RST_NIB;
			carry_flag_ff <= 1'b0;
			saved_cf_ff <= 1'b0;
		end
		else
		begin
			if (wr_ctrl && lane0)
				run_en_ff <= wr_data[`NSX_CTRL_RUN_BIT];
			accumulator_nibble_ff <= nxt_acc;
			carry_flag_ff <= nxt_cf;
			if (irq_enter)
				saved_cf_ff <= carry_flag_ff;
		end
	end

	// pc reload; plain return leaves carry alone
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pc_load_ff <= 1'b0;
			program_counter_ff <= '0;
		end
		else
		begin
			pc_load_ff <= is_ret || is_interrupt_return_op;
			if (is_ret || is_interrupt_return_op)
				program_counter_ff <= stack_pc;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			snd_channel_ff <= `NSX_RST_NIB;
			snd_repeat_ff <= 1'b0;
			snd_active_ff <= 1'b0;
			snd_start_ff <= 1'b0;
			snd_stop_ff <= 1'b0;
		end
		else
		begin
			snd_start_ff <= snd_go;
			snd_stop_ff <= is_off;
			snd_active_ff <= nxt_active;
			if (is_sndn)
				snd_channel_ff <= imm;
			else if (wr_sound && lane0)
				snd_channel_ff <= wr_data[3:0];
			if (is_loop)
				snd_repeat_ff <= 1'b1;
			else if (is_one)
				snd_repeat_ff <= 1'b0;
			else if (wr_sound && lane0)
				snd_repeat_ff <= wr_data[`NSX_SND_REP_BIT];
		end
	end
endmodule : nsx_core
`default_nettype wire

/* File: nsx_core_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module nsx_core_properties #(
	parameter int ADDR_W = 8,
	parameter int PC_W = 12
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic instr_valid,
	input wire logic [7:0] instr_byte,
	input wire logic instr_ready,
	input wire logic [3:0] pair_addressed_memory,
	input wire logic [PC_W-1:0] stack_pc,
	input wire logic irq_enter,
	input wire logic pc_load_ff,
	input wire logic [PC_W-1:0] program_counter_ff,
	input wire logic retire_ff,
	input wire logic [3:0] accumulator_nibble_ff,
	input wire logic carry_flag_ff,
	input wire logic [3:0] snd_channel_ff,
	input wire logic snd_repeat_ff,
	input wire logic snd_active_ff,
	input wire logic snd_start_ff,
	input wire logic snd_stop_ff
);
	logic opnd_ff;
	logic opk_ff;
	logic sv_ff;
	wire logic [3:0] a = accumulator_nibble_ff;
	wire logic cf = carry_flag_ff;
	wire logic take = instr_valid && instr_ready;
	wire logic op1 = take && !opnd_ff;
	wire logic op2 = take && opnd_ff;
	wire logic two = instr_byte == 8'h41 || instr_byte == 8'h45;
	wire logic [4:0] ac = {a, cf};
	wire logic [4:0] ca = {cf, a};
	// bit0 picks left, bit1 picks through carry
	wire logic [4:0] rot_v = instr_byte[0] ? {a[2:0], (instr_byte[1] ? cf : a[3]), a[3]}
		: {(instr_byte[1] ? cf : a[0]), a[3:1], a[0]};
	wire logic [4:0] sbc_v = {1'h0, a} + {1'h0, ~pair_addressed_memory} + {4'h0, cf};
	wire logic [4:0] sub_v = {1'h0, a} + {1'h0, ~instr_byte[3:0]} + 5'h01;
	// operand tracking mirrors the byte pairing, not the design state
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			opnd_ff <= 1'h0;
			opk_ff <= 1'h0;
			sv_ff <= 1'h0;
		end
		else
		begin
			if (take)
				opnd_ff <= op1 && two;
			if (op1)
				opk_ff <= instr_byte[2];
			if (irq_enter)
				sv_ff <= cf;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_rotate_ops:
	assert property (op1 && instr_byte[7:2] == 6'h00 |=> ac == $past(rot_v)) else $error("rotate");
	a_sbc_sum:
	assert property (op1 && instr_byte == 8'h0A |=> ca == $past(sbc_v)) else $error("sbc");
	a_sub_imm:
	assert property (op2 && !opk_ff |=> ca == $past(sub_v)) else $error("sub imm");
	a_stc_only:
	assert property (op1 && instr_byte == 8'h2B |=> cf && $stable(a)) else $error("stc");
	a_ret_pc:
	assert property (op1 && instr_byte[7:1] == 7'h17 |=> pc_load_ff
		&& program_counter_ff == $past(stack_pc)) else $error("return pc");
	a_interrupt_return_op_cf:
	assert property (op1 && instr_byte == 8'h2F |=> cf == $past(sv_ff)) else $error("interrupt_return_op carry");
	a_ret_cf:
	assert property (op1 && instr_byte == 8'h2E |=> $stable(cf)) else $error("ret carry");
	a_snd_chan:
	assert property (op2 && opk_ff |=> snd_start_ff && snd_active_ff
		&& snd_channel_ff == $past(instr_byte[3:0])) else $error("sound chan");
	a_snd_match:
	assert property (op1 && instr_byte == 8'h4B |=> snd_start_ff == ($past(a) == $past(snd_channel_ff)))
		else $error("sound acc");
	a_loop_one:
	assert property (op1 && instr_byte[7:1] == 7'h24 |=> snd_repeat_ff == $past(instr_byte[0]))
		else $error("sound mode");
	a_stop_now:
	assert property (op1 && instr_byte == 8'h4A |=> snd_stop_ff && !snd_active_ff) else $error("stop");
	a_cycle_count:
	assert property (op1 |=> retire_ff == !$past(two)) else $error("cycles");
endmodule : nsx_core_properties
bind nsx_core nsx_core_properties #(.ADDR_W(ADDR_W), .PC_W(PC_W)) nsx_core_properties_inst (.clk_sys,
	.rst_n, .instr_valid, .instr_byte, .instr_ready, .pair_addressed_memory, .stack_pc, .irq_enter,
	.pc_load_ff, .program_counter_ff, .retire_ff, .accumulator_nibble_ff, .carry_flag_ff,
	.snd_channel_ff, .snd_repeat_ff, .snd_active_ff, .snd_start_ff, .snd_stop_ff);
`default_nettype wire

/* File: nsx_core_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nsx_regs.svh"
module nsx_core_tb_top;
	logic clk_sys = 1'h0;
	logic rst_n = 1'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0, instr_valid = 1'h0, irq_enter = 1'h0, snd_done = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, instr_byte = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF, pair_addressed_memory = 4'h0;
	logic [11:0] stack_pc = 12'h000, pcx;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, instr_ready;
	wire pc_load_ff, retire_ff, carry_flag_ff, snd_repeat_ff, snd_active_ff, snd_start_ff, snd_stop_ff;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [11:0] program_counter_ff;
	wire [3:0] accumulator_nibble_ff, snd_channel_ff;
	int errors = 0, compares = 0, i;
	logic [4:0] iq[$];
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	logic [11:0] pq[$];
	logic [5:0] sq[$];
	logic [3:0] m_acc = 4'h0;
	logic m_cf = 1'h0, m_sv = 1'h0;
	logic [7:0] ops [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0A, 8'h41, 8'h2B};
	nsx_core nsx_core_inst (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .instr_valid, .instr_byte, .instr_ready, .pair_addressed_memory,
		.stack_pc, .irq_enter, .snd_done, .pc_load_ff, .program_counter_ff, .retire_ff,
		.accumulator_nibble_ff, .carry_flag_ff, .snd_channel_ff, .snd_repeat_ff, .snd_active_ff,
		.snd_start_ff, .snd_stop_ff);
	initial forever #20 clk_sys = ~clk_sys;
	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		compares++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	task automatic test_done;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done
	task automatic to(input int n);
		if (n >= 50)
		begin
			errors++;
			test_done;
		end
	endtask : to
	// results are judged where they appear, notes come from the drivers
	always @(posedge clk_sys)
	begin
		if (retire_ff === 1'h1)
			chk(34'({carry_flag_ff, accumulator_nibble_ff}), 34'(iq.pop_front()));
		if (s_axi_rvalid === 1'h1 && s_axi_rready)
			chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
		if (s_axi_bvalid === 1'h1 && s_axi_bready)
			chk(34'(s_axi_bresp), 34'(bq.pop_front()));
		if (pc_load_ff === 1'h1)
			chk(34'(program_counter_ff), 34'(pq.pop_front()));
		if (snd_start_ff === 1'h1 || snd_stop_ff === 1'h1)
			chk(34'({snd_start_ff, snd_stop_ff, snd_channel_ff}), 34'(sq.pop_front()));
	end
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		@(posedge clk_sys);
		bq.push_back(e);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
			if (s_axi_awready === 1'h1)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready === 1'h1)
				s_axi_wvalid <= 1'h0;
		end
		while (s_axi_bvalid !== 1'h1 && n < 50);
		s_axi_bready <= 1'h0;
		to(n);
	endtask : axw
	task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		@(posedge clk_sys);
		rq.push_back({e, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
			if (s_axi_arready === 1'h1)
				s_axi_arvalid <= 1'h0;
		end
		while (s_axi_rvalid !== 1'h1 && n < 50);
		s_axi_rready <= 1'h0;
		to(n);
	endtask : axr
	task automatic send(input logic [7:0] b);
		int n;
		instr_valid <= 1'h1;
		instr_byte <= b;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (instr_ready !== 1'h1 && n < 50);
		to(n);
	endtask : send
	task automatic idle;
		instr_valid <= 1'h0;
		@(posedge clk_sys);
	endtask : idle
	task automatic st(input logic [3:0] a, input logic c);
		axw(`NSX_REG_STATE, {27'h0, c, a}, `NSX_RESP_OKAY);
		m_acc = a;
		m_cf = c;
	endtask : st
	task automatic op(input logic [7:0] b, input logic [3:0] x);
		pair_addressed_memory <= x;
		send(b);
		if (b == `NSX_OP_SUBI || b == `NSX_OP_SNDN)
			send({4'h0, x});
		case (b)
			`NSX_OP_RR: {m_acc, m_cf} = {m_acc[0], m_acc[3:1], m_acc[0]};
			`NSX_OP_RL: {m_acc, m_cf} = {m_acc[2:0], m_acc[3], m_acc[3]};
			`NSX_OP_RRC: {m_acc, m_cf} = {m_cf, m_acc[3:1], m_acc[0]};
			`NSX_OP_RLC: {m_acc, m_cf} = {m_acc[2:0], m_cf, m_acc[3]};
			`NSX_OP_SBC: {m_cf, m_acc} = {1'h0, m_acc} + {1'h0, ~x} + {4'h0, m_cf};
			`NSX_OP_SUBI: {m_cf, m_acc} = {1'h0, m_acc} + {1'h0, ~x} + 5'h01;
			`NSX_OP_STC: m_cf = 1'h1;
			`NSX_OP_INTERRUPT_RETURN_OP: m_cf = m_sv;
			default: m_cf = m_cf;
		endcase
		iq.push_back({m_cf, m_acc});
	endtask : op
	initial
	begin
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'h1;
		void'($urandom(82));
		axr(`NSX_REG_CTRL, 32'h0, `NSX_RESP_OKAY);
		axw(8'h10, 32'h1, `NSX_RESP_SLVERR);
		axr(8'h10, 32'h0, `NSX_RESP_SLVERR);
		axw(`NSX_REG_CTRL, 32'h1, `NSX_RESP_OKAY);
		for (i = 0; i < 64; i++)
		begin
			if (i % 8 == 0)
			begin
				idle;
				st(4'($urandom), 1'($urandom));
			end
			op(ops[$urandom % 7], 4'($urandom));
		end
		idle;
		st(4'h0, 1'h0);
		op(`NSX_OP_SUBI, 4'h1);
		op(`NSX_OP_SBC, 4'hF);
		idle;
		irq_enter <= 1'h1;
		@(posedge clk_sys);
		irq_enter <= 1'h0;
		m_sv = m_cf;
		pcx = 12'($urandom);
		stack_pc <= pcx;
		op(`NSX_OP_STC, 4'h0);
		pq.push_back(pcx);
		op(`NSX_OP_INTERRUPT_RETURN_OP, 4'h0);
		idle;
		stack_pc <= ~pcx;
		pq.push_back(~pcx);
		op(`NSX_OP_RET, 4'h0);
		idle;
		sq.push_back(6'h29);
		op(`NSX_OP_SNDN, 4'h9);
		op(`NSX_OP_SNDLOOP, 4'h0);
		idle;
		axr(`NSX_REG_SOUND, 32'h39, `NSX_RESP_OKAY);
		sq.push_back(6'h19);
		op(`NSX_OP_SNDOFF, 4'h0);
		op(`NSX_OP_SNDONE, 4'h0);
		idle;
		axr(`NSX_REG_SOUND, 32'h09, `NSX_RESP_OKAY);
		st(4'h9, 1'h0);
		sq.push_back(6'h29);
		op(`NSX_OP_SNDA, 4'h0);
		idle;
		axr(`NSX_REG_SOUND, 32'h29, `NSX_RESP_OKAY);
		snd_done <= 1'h1;
		@(posedge clk_sys);
		snd_done <= 1'h0;
		axr(`NSX_REG_SOUND, 32'h09, `NSX_RESP_OKAY);
		st(4'h3, 1'h0);
		op(`NSX_OP_SNDA, 4'h0);
		idle;
		axr(`NSX_REG_SOUND, 32'h09, `NSX_RESP_OKAY);
		axr(`NSX_REG_LASTOP, 32'h4B, `NSX_RESP_OKAY);
		// a leftover note means a result never showed up
		chk(34'(iq.size() + pq.size() + sq.size()), 34'h0);
		rst_n <= 1'h0;
		@(posedge clk_sys);
		rst_n <= 1'h1;
		axr(`NSX_REG_CTRL, 32'h0, `NSX_RESP_OKAY);
		axr(`NSX_REG_SOUND, 32'h0, `NSX_RESP_OKAY);
		test_done;
	end
endmodule : nsx_core_tb_top
`default_nettype wire
